// >>> rtl/cfr_pkg.sv
package cfr_pkg;
   // ****************************************************************
   // Widths and positions
   // ****************************************************************
   localparam int          CFR_DATA_W     = 8;
   localparam int          CFR_FLAG_W     = 5;
   localparam int          CFR_BUS_W      = 64;
   localparam int          CFR_BUS_LO     = 32;
   localparam int          CFR_POS_DC     = 0;
   localparam int          CFR_POS_CMD    = 1;
   localparam int          CFR_POS_SLI    = 2;
   localparam int          CFR_POS_SKIP   = 3;
   localparam int          CFR_POS_PCI    = 4;
   localparam int          CFR_BUSIN_FLAG_LO = 16;
   localparam int          CFR_BUSIN_PAR  = 62;
   localparam logic [7:0]  CFR_DATA_RST   = 8'h00;
   localparam logic        CFR_PAR_RST    = 1'b1;
   // Cycles the load-pending latch outlives the ingate reset
   localparam int          CFR_PEND_HOLD  = 1;
   // ****************************************************************
   // APB map
   // ****************************************************************
   localparam logic [7:0]  CFR_OFS_FLAGS  = 8'h00;
   localparam logic [7:0]  CFR_OFS_CTRL   = 8'h04;
   localparam logic [7:0]  CFR_OFS_STAT   = 8'h08;
   localparam int          CFR_ADDR_W     = 8;
endpackage

// >>> rtl/cfr_sync2.sv
`timescale 1ns/10ps
module cfr_sync2
   import cfr_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] dout_q;
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         meta_q <= '0;
         dout_q <= '0;
      end
      else if (clk_en)
      begin
         meta_q <= din;
         dout_q <= meta_q;
      end
   end
   assign dout = dout_q;
endmodule

// >>> rtl/cfr_parity.sv
`timescale 1ns/10ps
module cfr_parity
   import cfr_pkg::*;
#(
   parameter int W = 9
)(
   input  wire logic [W-1:0] bits,
   output logic              odd_ok
);
   // Odd count of ones means a good field
   assign odd_ok = ^bits;
endmodule

// >>> rtl/cfr_flag_reg.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module cfr_flag_reg
   import cfr_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire logic                  clk_en,
   input  wire logic                  machine_setup_reset,
   input  wire logic                  transfer_in_channel,
   input  wire logic                  gate_count_addr,
   input  wire logic [CFR_BUS_W-1:0]  storage_bus_out,
   input  wire logic                  flag_field_parity_in,
   input  wire logic                  force_read_in,
   input  wire logic                  chain_cmd_start,
   input  wire logic                  sample_parity,
   input  wire logic                  read_op,
   input  wire logic                  sense_op,
   input  wire logic                  status_cond,
   input  wire logic                  logout_word2,
   input  wire logic                  logout_word3,
   input  wire logic [CFR_ADDR_W-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       data_chain,
   output logic                       command_chain,
   output logic                       suppress_length_indication,
   output logic                       skip,
   output logic                       program_controlled_interrupt,
   output logic                       flag_parity,
   output logic                       flag_parity_check,
   output logic                       channel_control_check,
   output logic                       dc_enable,
   output logic                       cmd_chain_enable,
   output logic                       cmd_addr_jump,
   output logic                       length_check_block,
   output logic                       store_block,
   output logic                       intr_request,
   output logic [CFR_BUS_W-1:0]       storage_bus_in
);
   // ****************************************************************
   // Pin inputs
   // ****************************************************************
   // The force signal comes from the console domain, so it is synced
   logic force_read;
   cfr_sync2 #(.W(1)) u_sync
   (
      .clock (clock),
      .rst_b (rst_b),
      .clk_en(clk_en),
      .din   (force_read_in),
      .dout  (force_read)
   );

   // ****************************************************************
   // Gating control
   // ****************************************************************
   logic [CFR_DATA_W-1:0] data_q;
   logic [CFR_DATA_W-1:0] data_d;
   logic                  par_q;
   logic                  par_d;
   logic                  pend_q;
   logic                  pend_d;
   logic                  force_q;
   logic                  force_d;
   logic                  ccc_q;
   logic                  fpc_q;
   logic                  sw_clr_q;
   logic                  sw_force_q;
   logic                  ingate_reset;
   logic                  load_strobe;
   logic                  pend_set;
   logic                  par_ok;
   logic                  force_eff;

   assign ingate_reset = transfer_in_channel | machine_setup_reset | gate_count_addr;
   assign pend_set     = gate_count_addr & ~transfer_in_channel;
   // Load only after the reset has fallen, one cycle of pending overlap
   assign load_strobe  = pend_q & ~ingate_reset;
   // Pending drops on the edge that loads: a later bus value is never taken
   assign pend_d       = transfer_in_channel ? 1'b0 :
                         pend_set ? 1'b1 :
                         (ingate_reset ? pend_q : 1'b0);

   assign data_d = ingate_reset ? CFR_DATA_RST :
                   load_strobe  ? storage_bus_out[CFR_BUS_LO +: CFR_DATA_W] :
                   data_q;
   assign par_d  = ingate_reset ? CFR_PAR_RST :
                   load_strobe  ? flag_field_parity_in :
                   par_q;

   // Force stays until the first chain command of the load sequence
   assign force_d = chain_cmd_start ? 1'b0 : ((force_read | sw_force_q) ? 1'b1 : force_q);

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         data_q   <= CFR_DATA_RST;
         par_q    <= CFR_PAR_RST;
         pend_q   <= 1'b0;
         force_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         data_q   <= data_d;
         par_q    <= par_d;
         pend_q   <= pend_d;
         force_q  <= force_d;
      end
   end

   // ****************************************************************
   // Parity check
   // ****************************************************************
   // Spare bits are not forced to zero; a bad field shows as a check
   cfr_parity #(.W(CFR_DATA_W + 1)) u_par
   (
      .bits  ({par_q, data_q}),
      .odd_ok(par_ok)
   );

   logic fpc_d;
   logic ccc_d;
   assign force_eff = force_q & ~chain_cmd_start;
   // Hold off the check while forcing: forced parity would mislead it
   assign fpc_d = sample_parity & ~par_ok & ~force_q;
   assign ccc_d = fpc_q | (ccc_q & ~sw_clr_q);

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         fpc_q <= 1'b0;
         ccc_q <= 1'b0;
      end
      else if (clk_en)
      begin
         fpc_q <= fpc_d;
         ccc_q <= ccc_d;
      end
   end

   // ****************************************************************
   // Flag outputs and logout
   // ****************************************************************
   logic [CFR_FLAG_W-1:0] flags_v;
   logic                  par_out;
   logic [CFR_BUS_W-1:0]  busin_d;
   logic [5:0]            ctl_d;
   assign flags_v = data_q[CFR_FLAG_W-1:0] | ({{(CFR_FLAG_W-1){1'b0}}, force_eff} << CFR_POS_CMD);
   assign par_out = par_q | force_eff;
   always_comb
   begin
      busin_d = '0;
      if (logout_word2)
         busin_d[CFR_BUSIN_FLAG_LO +: CFR_FLAG_W] = flags_v;
      if (logout_word3)
         busin_d[CFR_BUSIN_PAR] = par_out;
   end
   assign ctl_d[0] = flags_v[CFR_POS_DC];
   assign ctl_d[1] = flags_v[CFR_POS_CMD] & ~flags_v[CFR_POS_DC];
   assign ctl_d[2] = flags_v[CFR_POS_CMD] & flags_v[CFR_POS_DC] & status_cond;
   assign ctl_d[3] = flags_v[CFR_POS_SLI];
   assign ctl_d[4] = flags_v[CFR_POS_SKIP] & (read_op | sense_op);
   assign ctl_d[5] = flags_v[CFR_POS_PCI];

   logic [CFR_FLAG_W-1:0] flags_q;
   logic                  parout_q;
   logic [5:0]            ctl_q;
   logic [CFR_BUS_W-1:0]  busin_q;
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         flags_q  <= '0;
         parout_q <= CFR_PAR_RST;
         ctl_q    <= '0;
         busin_q  <= '0;
      end
      else if (clk_en)
      begin
         flags_q  <= flags_v;
         parout_q <= par_out;
         ctl_q    <= ctl_d;
         busin_q  <= busin_d;
      end
   end
   assign data_chain                   = flags_q[CFR_POS_DC];
   assign command_chain                = flags_q[CFR_POS_CMD];
   assign suppress_length_indication   = flags_q[CFR_POS_SLI];
   assign skip                         = flags_q[CFR_POS_SKIP];
   assign program_controlled_interrupt = flags_q[CFR_POS_PCI];
   assign flag_parity                  = parout_q;
   assign flag_parity_check            = fpc_q;
   assign channel_control_check        = ccc_q;
   assign dc_enable                    = ctl_q[0];
   assign cmd_chain_enable             = ctl_q[1];
   assign cmd_addr_jump                = ctl_q[2];
   assign length_check_block           = ctl_q[3];
   assign store_block                  = ctl_q[4];
   assign intr_request                 = ctl_q[5];
   assign storage_bus_in               = busin_q;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   logic        acc;
   logic        hit_flags;
   logic        hit_ctrl;
   logic        hit_stat;
   logic [31:0] rd_d;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   assign acc       = psel & penable;
   assign hit_flags = paddr == CFR_OFS_FLAGS;
   assign hit_ctrl  = paddr == CFR_OFS_CTRL;
   assign hit_stat  = paddr == CFR_OFS_STAT;
   assign rd_d = hit_flags ? {23'h000000, par_q, data_q} :
                 hit_ctrl  ? {31'h00000000, sw_force_q} :
                 hit_stat  ? {28'h0000000, force_q, pend_q, fpc_q, ccc_q} :
                 32'h00000000;
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         prdata_q   <= 32'h00000000;
         pslverr_q  <= 1'b0;
         sw_force_q <= 1'b0;
         sw_clr_q   <= 1'b0;
      end
      else if (clk_en)
      begin
         prdata_q   <= (psel & ~penable & ~pwrite) ? rd_d : prdata_q;
         pslverr_q  <= psel & ~penable & ~(hit_flags | hit_ctrl | hit_stat);
         sw_force_q <= (acc & pwrite & hit_ctrl) ? pwdata[0] : sw_force_q;
         sw_clr_q   <= acc & pwrite & hit_stat & pwdata[0];
      end
   end
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;
   assign pready  = 1'b1;

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_reset_zero: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && ingate_reset |=> data_q == CFR_DATA_RST && par_q)
      else $error("ingate reset did not clear register");
   chk_tic_block: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && transfer_in_channel |=> !pend_q)
      else $error("pending set during transfer word");
   sequence s_gate;
      clk_en && pend_set;
   endsequence
   sequence s_load;
      clk_en && load_strobe;
   endsequence
   chk_gate_load: assert property (@(posedge clock) disable iff (!rst_b)
      s_gate ##1 (clk_en && !ingate_reset) |-> load_strobe)
      else $error("load did not follow gate strobe");
   chk_load_copy: assert property (@(posedge clock) disable iff (!rst_b)
      s_load |=> data_q == $past(storage_bus_out[39:32])
                 && par_q == $past(flag_field_parity_in))
      else $error("load did not copy bus bits");
   chk_hold_data: assert property (@(posedge clock) disable iff (!rst_b)
      !ingate_reset && !load_strobe |=> $stable(data_q) && $stable(par_q))
      else $error("register changed between loads");
   chk_par_check: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && sample_parity && !par_ok && !force_q |=> flag_parity_check)
      else $error("parity error not flagged");
   chk_ccc_set: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && flag_parity_check |=> channel_control_check)
      else $error("control check not set");
   chk_force_out: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && force_q && !chain_cmd_start |=> command_chain && flag_parity)
      else $error("force did not drive outputs");
   chk_logout: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && logout_word3 |=> storage_bus_in[CFR_BUSIN_PAR] == $past(par_out))
      else $error("logout parity line wrong");

   // ****************************************************************
   // Sequencing checks
   // ****************************************************************
   // Each fetch takes the bus once: a second load would pick up
   // whatever the storage side drives after it lets go
   sequence s_clear;
      clk_en && chain_cmd_start;
   endsequence

   chk_load_once: assert property (@(posedge clock) disable iff (!rst_b)
      s_load |=> !pend_q)
      else $error("pending still set after load");
   chk_pend_set: assert property (@(posedge clock) disable iff (!rst_b)
      s_gate |=> pend_q)
      else $error("gate strobe did not set pending");
   chk_tic_noload: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && transfer_in_channel |=> !load_strobe)
      else $error("load after transfer word");

   chk_machine_reset: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && machine_setup_reset |=> data_q == CFR_DATA_RST && par_q)
      else $error("machine reset did not clear register");
   chk_force_clear: assert property (@(posedge clock) disable iff (!rst_b)
      s_clear |=> !force_q)
      else $error("chain command did not end force");

   chk_par_good: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && sample_parity && par_ok |=> !flag_parity_check)
      else $error("parity check on good field");
   chk_no_sample: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && !sample_parity |=> !flag_parity_check)
      else $error("parity check without sample strobe");

   chk_ccc_sticky: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && channel_control_check && !sw_clr_q |=> channel_control_check)
      else $error("control check dropped on its own");
   chk_sw_clear: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && sw_clr_q && !fpc_q |=> !channel_control_check)
      else $error("control check not cleared");

   chk_logout_flags: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && logout_word2 |=> storage_bus_in[CFR_BUSIN_FLAG_LO +: CFR_FLAG_W] == $past(flags_v))
      else $error("logout flag lines wrong");
endmodule

// >>> bench/cfr_chan_model.sv
`timescale 1ns/10ps
module cfr_chan_model
   import cfr_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 go,
   input  wire logic                 xfer_req,
   input  wire logic [CFR_BUS_W-1:0] word,
   input  wire logic                 par_req,
   output logic                      gate_count_addr      = 1'b0,
   output logic                      transfer_in_channel  = 1'b0,
   output logic      [CFR_BUS_W-1:0] storage_bus_out      = '0,
   output logic                      flag_field_parity_in = 1'b0,
   output logic                      done                 = 1'b0
);
   logic [1:0] step_q = 2'h0;
   // **************************************
   // Fetch: gate strobe, bus hold, release
   // **************************************
   always @(posedge clock)
   begin
      done <= 1'b0;
      case (step_q)
         2'h0:
         begin
            if (go)
            begin
               gate_count_addr      <= 1'b1;
               transfer_in_channel  <= xfer_req;
               storage_bus_out      <= word;
               flag_field_parity_in <= par_req;
               step_q               <= 2'h1;
            end
         end
         2'h1:
         begin
            gate_count_addr <= 1'b0;
            step_q          <= 2'h2;
         end
         default:
         begin
            // Released bus flips so a late load shows up
            transfer_in_channel  <= 1'b0;
            storage_bus_out      <= ~storage_bus_out;
            flag_field_parity_in <= ~flag_field_parity_in;
            done                 <= 1'b1;
            step_q               <= 2'h0;
         end
      endcase
   end
endmodule

// >>> bench/cfr_flag_reg_tb.sv
`timescale 1ns/10ps
module cfr_flag_reg_tb
   import cfr_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b, clk_en, machine_setup_reset, force_read_in, chain_cmd_start, sample_parity;
   logic read_op, sense_op, status_cond, logout_word2, logout_word3, psel, penable, pwrite;
   logic go, xfer_req, par_req, err, seen, exp_p;
   logic gate_count_addr, transfer_in_channel, flag_field_parity_in, done;
   logic data_chain, command_chain, suppress_length_indication, skip;
   logic program_controlled_interrupt, flag_parity, flag_parity_check, channel_control_check;
   logic dc_enable, cmd_chain_enable, cmd_addr_jump, length_check_block, store_block;
   logic intr_request, pready, pslverr;
   logic [CFR_ADDR_W-1:0] paddr;
   logic [31:0]           pwdata, prdata, rd;
   logic [63:0]           word, storage_bus_out, storage_bus_in;
   logic [7:0]            exp_d, f;
   logic [4:0]            flags_w;
   logic [5:0]            ctl_w;
   int                    err_count = 0;
   int                    tests_run = 0;
   integer                seed = 32'hc69f;
   assign flags_w = {program_controlled_interrupt, skip, suppress_length_indication,
                     command_chain, data_chain};
   assign ctl_w = {dc_enable, cmd_chain_enable, cmd_addr_jump, length_check_block,
                   store_block, intr_request};
   always #4 clock = ~clock;
   cfr_flag_reg cfr_flag_reg_i (
      .clock, .rst_b, .clk_en, .machine_setup_reset, .transfer_in_channel, .gate_count_addr,
      .storage_bus_out, .flag_field_parity_in, .force_read_in, .chain_cmd_start,
      .sample_parity, .read_op, .sense_op, .status_cond, .logout_word2, .logout_word3,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .data_chain,
      .command_chain, .suppress_length_indication, .skip, .program_controlled_interrupt,
      .flag_parity, .flag_parity_check, .channel_control_check, .dc_enable,
      .cmd_chain_enable, .cmd_addr_jump, .length_check_block, .store_block, .intr_request,
      .storage_bus_in
   );
   cfr_chan_model cfr_chan_model_i (
      .clock, .go, .xfer_req, .word, .par_req, .gate_count_addr, .transfer_in_channel,
      .storage_bus_out, .flag_field_parity_in, .done
   );
   // ********************
   // Helpers
   // ********************
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Waits on pready rather than assuming the one-cycle access
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge clock);
      end
      chk(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic load(input logic [7:0] fl, input logic p, input logic t);
      logic [63:0] w;
      int          n;
      n = 0;
      w = {$random(seed), $random(seed)};
      w[39:32] = fl;
      word    <= w;
      par_req <= p;
      xfer_req <= t;
      go      <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      while (done !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clock);
      end
      chk(done, 1'b1);
      tick(3);
      {exp_p, exp_d} = t ? 9'h100 : {p, fl};
   endtask
   function automatic logic [63:0] exp_busin;
      exp_busin = '0;
      if (logout_word2)
         exp_busin[20:16] = exp_d[4:0];
      if (logout_word3)
         exp_busin[62] = exp_p;
   endfunction
   function automatic logic [5:0] exp_ctl;
      exp_ctl = {exp_d[0], exp_d[1] & ~exp_d[0], &exp_d[1:0] & status_cond, exp_d[2],
                 exp_d[3] & (read_op | sense_op), exp_d[4]};
   endfunction
   task automatic check_state;
      chk(flags_w, exp_d[4:0]);
      chk(flag_parity, exp_p);
      chk(storage_bus_in, exp_busin());
      chk(ctl_w, exp_ctl());
      apb(1'b0, CFR_OFS_FLAGS, 32'h0);
      chk(rd, {23'h0, exp_p, exp_d});
   endtask
   // ********************
   // Main sequence
   // ********************
   initial
   begin
      {rst_b, machine_setup_reset, force_read_in, chain_cmd_start, sample_parity, read_op,
       sense_op, status_cond, logout_word2, logout_word3, psel, penable, pwrite, go,
       xfer_req, par_req, paddr, pwdata, word} = '0;
      clk_en = 1'b1;
      {exp_p, exp_d} = 9'h100;
      tick(2);
      rst_b <= 1'b1;
      tick(1);
      check_state;
      for (int i = 0; i < 24; i++)
      begin
         {sample_parity, status_cond, read_op, sense_op, logout_word2, logout_word3}
            <= 6'($random(seed));
         f = (i < 2) ? {3'h0, {5{i[0]}}} : {3'h0, 5'($random(seed))};
         load(f, ~^f, 1'b0);
         check_state;
         chk(channel_control_check, 1'b0);
      end
      // A low clock enable must swallow the reset pulse
      clk_en              <= 1'b0;
      machine_setup_reset <= 1'b1;
      tick(2);
      clk_en              <= 1'b1;
      machine_setup_reset <= 1'b0;
      tick(2);
      check_state;
      apb(1'b1, CFR_OFS_FLAGS, 32'h1FF);
      check_state;
      apb(1'b0, 8'h0C, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      load(8'h0E, 1'b0, 1'b1);
      check_state;
      load(8'h15, 1'b0, 1'b0);
      machine_setup_reset <= 1'b1;
      tick(1);
      machine_setup_reset <= 1'b0;
      tick(3);
      {exp_p, exp_d} = 9'h100;
      check_state;
      sample_parity <= 1'b0;
      load(8'h03, 1'b0, 1'b0);
      tick(4);
      chk(channel_control_check, 1'b0);
      sample_parity <= 1'b1;
      tick(1);
      sample_parity <= 1'b0;
      seen = 1'b0;
      repeat (4)
      begin
         @(posedge clock);
         seen = seen | (flag_parity_check === 1'b1);
      end
      chk(seen, 1'b1);
      chk(channel_control_check, 1'b1);
      apb(1'b1, CFR_OFS_STAT, 32'h1);
      tick(1);
      chk(channel_control_check, 1'b0);
      for (int s = 0; s < 2; s++)
      begin
         load(8'h01, 1'b0, 1'b0);
         if (s == 0)
         begin
            apb(1'b1, CFR_OFS_CTRL, 32'h1);
            apb(1'b1, CFR_OFS_CTRL, 32'h0);
         end
         else
         begin
            force_read_in <= 1'b1;
            tick(3);
            force_read_in <= 1'b0;
         end
         tick(3);
         chk({command_chain, flag_parity}, 2'b11);
         chain_cmd_start <= 1'b1;
         tick(1);
         chain_cmd_start <= 1'b0;
         tick(3);
         chk({command_chain, flag_parity}, 2'b00);
      end
      report_and_stop;
   end
   initial
   begin
      #(8 * 20000);
      err_count++;
      report_and_stop;
   end
endmodule
